// [dsc_debug_ctrl.sv]
module dsc_debug_ctrl
   import dsc_pkg::*;
(
   input wire logic mclk, // 200 MHz clock
   input wire logic reset_n, // any reset, active low
   input wire logic porReset_n, // power-on reset, active low
   input wire logic hsel, // ahb select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb ready in
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb ready out
   output logic hresp, // ahb response
   input wire logic secured, // device secured
   input wire logic traceReqEnable, // trace request enable
   input wire logic triggerAlignBegin, // trigger before storing data
   input wire logic bgCtrlEnable, // background controller enable
   input wire logic bgActive, // background mode active
   input wire logic [2:0] seqNext, // comparator-driven next state
   input wire logic seqAdvance, // take seqNext this cycle
   input wire logic lineStored, // one trace line stored
   input wire logic traceDone, // tracing session complete
   output logic sessionArmed, // session enable
   output logic [1:0] compBank, // bank in window 0x28..0x2f
   output logic [1:0] reg27Sel, // 0..2 seq ctrl a..c, 3 match flags
   output logic traceActive, // tracing in progress
   output logic haltOut, // background halt request
   output logic swiOut // software interrupt request
);
   logic armed_r;
   logic route_r;
   logic brkFinal_r;
   logic [1:0] bank_r;
   dsc_state_t state_r;
   logic full_r;
   logic [6:0] lines_r;
   logic tracing_r;
   logic pendBrk_r;
   logic aPhase_r;
   logic aWrite_r;
   logic [31:0] aAddr_r;
   logic [31:0] rdata_r;
   logic haltReq;
   logic swiReq;
   logic wrCtrl;
   logic armSet;
   logic trigWr;
   logic traceOk;
   logic reachFinal;
   logic brkNow;
   logic endSession;
   logic [7:0] statVal;
   logic [7:0] ctrlVal;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aPhase_r <= 1'b0;
         aWrite_r <= 1'b0;
         aAddr_r <= 32'h0000_0000;
      end else if (hready) begin
         aPhase_r <= hsel && htrans[1];
         aWrite_r <= hwrite;
         aAddr_r <= haddr;
      end
   end

   assign wrCtrl = aPhase_r && aWrite_r && aAddr_r == DSC_CTRL_ADDR;
   assign armSet = wrCtrl && hwdata[DSC_ENA_BIT];
   assign traceOk = traceReqEnable && !secured;
   // a forced trigger after begin-aligned tracing started is ignored
   assign trigWr = wrCtrl && hwdata[DSC_FORCED_TRIGGER_REQUEST_BIT] && armed_r
      && !(tracing_r && triggerAlignBegin);
   assign reachFinal = armed_r && state_r != DSC_SF
      && (trigWr || (seqAdvance && seqNext == DSC_SF));
   assign brkNow = (reachFinal && brkFinal_r && !traceOk)
      || (pendBrk_r && traceDone);
   assign endSession = armed_r && ((tracing_r && traceDone)
      || (reachFinal && !traceOk));

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         armed_r <= DSC_CTRL_RST[DSC_ENA_BIT];
         bank_r <= DSC_CTRL_RST[DSC_BANK_LSB +: 2];
      end else if (wrCtrl) begin
         // a session ending in the same cycle wins over the written value
         armed_r <= hwdata[DSC_ENA_BIT] && !endSession;
         bank_r <= hwdata[DSC_BANK_LSB +: 2];
      end else if (endSession) begin
         armed_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         route_r <= DSC_CTRL_RST[DSC_ROUTE_BIT];
         brkFinal_r <= DSC_CTRL_RST[DSC_BRK_BIT];
      end else if (wrCtrl && !armed_r) begin
         route_r <= hwdata[DSC_ROUTE_BIT];
         brkFinal_r <= hwdata[DSC_BRK_BIT];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= DSC_S0;
      end else if (armSet && !armed_r) begin
         state_r <= DSC_S1;
      end else if (endSession) begin
         state_r <= DSC_S0;
      end else if (reachFinal) begin
         state_r <= DSC_SF;
      end else if (armed_r && seqAdvance && state_r != DSC_SF) begin
         unique case (seqNext)
            3'b001: state_r <= DSC_S1;
            3'b010: state_r <= DSC_S2;
            3'b011: state_r <= DSC_S3;
            default: state_r <= state_r;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tracing_r <= 1'b0;
         pendBrk_r <= 1'b0;
      end else if (armSet && !armed_r) begin
         tracing_r <= 1'b0;
         pendBrk_r <= 1'b0;
      end else if (tracing_r && traceDone) begin
         tracing_r <= 1'b0;
         pendBrk_r <= 1'b0;
      end else if (reachFinal && traceOk) begin
         tracing_r <= 1'b1;
         pendBrk_r <= brkFinal_r || trigWr;
      end
   end

   always_ff @(posedge mclk or negedge porReset_n) begin
      if (!porReset_n) begin
         full_r <= 1'b0;
         lines_r <= 7'h00;
      end else if (armSet) begin
         full_r <= 1'b0;
         lines_r <= 7'h00;
      end else if (lineStored && tracing_r && !full_r) begin
         lines_r <= lines_r + 7'h01;
         full_r <= lines_r + 7'h01 >= DSC_FULL_LINES;
      end
   end

   dsc_break_route uRoute (
      .breakReq(brkNow),
      .haltRoute(route_r),
      .bgEnable(bgCtrlEnable),
      .bgActive(bgActive),
      .haltReq(haltReq),
      .swiReq(swiReq)
   );

   // trigger and unused bits read zero
   assign ctrlVal = {armed_r, 2'b00, route_r, brkFinal_r, 1'b0,
      bank_r};
   assign statVal = {full_r, 4'h0, state_r};

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (haddr == DSC_CTRL_ADDR) begin
            rdata_r <= {24'h000000, ctrlVal};
         end else if (haddr == DSC_STAT_ADDR) begin
            rdata_r <= {24'h000000, statVal};
         end else begin
            rdata_r <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sessionArmed <= 1'b0;
         compBank <= 2'h0;
         reg27Sel <= 2'h0;
         traceActive <= 1'b0;
         haltOut <= 1'b0;
         swiOut <= 1'b0;
      end else begin
         sessionArmed <= armed_r;
         compBank <= bank_r;
         reg27Sel <= bank_r;
         traceActive <= tracing_r;
         haltOut <= haltReq;
         swiOut <= swiReq;
      end
   end

   assign hrdata = rdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule

// [dsc_pkg.sv]
// Contract
// - session enable and bank select bits are writable at any time
// - forced trigger write accepted only while armed; bit always reads as zero
// - halt route and break-on-final bits writable only while disarmed
// - session enable self-clears at trace completion or on reaching Final State untraced
// - setting session enable moves the sequencer into State1
// - forced trigger one jumps to Final State; zero does nothing
// - no tracing when trace request enable is clear
// - forced trigger ignored once begin-aligned tracing has started
// - while secured, tracing disabled; forced trigger never starts tracing
// - halt route set: halt if controller enabled, else software interrupt
// - halt route clear: software interrupt unless background active
// - break-on-final requests breakpoint at Final State, after trace if tracing
// - bank select chooses comparator bank in window 0x28 to 0x2f
// - bank select chooses sequencer control a/b/c or match flags at 0x27
// - status register readable anytime, writes ignored
// - trace full set at 64 lines, cleared when session enable written one
// - trace full cleared by power-on reset, not by the ordinary reset
// - state flags: 000 disarmed, 001-011 states, 100 final; arming gives 001; a write clearing session enable leaves the state flags unchanged
// - while armed only enable, trigger and bank select bits are writable
package dsc_pkg;
   localparam logic [31:0] DSC_CTRL_OFS = 32'h0000_0020;
   localparam logic [31:0] DSC_STAT_OFS = 32'h0000_0021;
   localparam logic [31:0] DSC_CTRL_ADDR = {DSC_CTRL_OFS[29:0], 2'h0};
   localparam logic [31:0] DSC_STAT_ADDR = {DSC_STAT_OFS[29:0], 2'h0};
   localparam int DSC_ENA_BIT = 7;
   localparam int DSC_FORCED_TRIGGER_REQUEST_BIT = 6;
   localparam int DSC_ROUTE_BIT = 4;
   localparam int DSC_BRK_BIT = 3;
   localparam int DSC_BANK_LSB = 0;
   localparam int DSC_FULL_BIT = 7;
   localparam logic [7:0] DSC_CTRL_RST = 8'h00;
   localparam logic [6:0] DSC_FULL_LINES = 7'h40;
   localparam logic [1:0] DSC_BANK_NONE = 2'h3;
   typedef enum logic [2:0] {
      DSC_S0 = 3'b000,
      DSC_S1 = 3'b001,
      DSC_S2 = 3'b010,
      DSC_S3 = 3'b011,
      DSC_SF = 3'b100
   } dsc_state_t;
endpackage

// [dsc_break_route.sv]
module dsc_break_route
   import dsc_pkg::*;
(
   input wire logic breakReq, // breakpoint request
   input wire logic haltRoute, // halt route select
   input wire logic bgEnable, // background controller enabled
   input wire logic bgActive, // background mode active
   output logic haltReq, // to background halt
   output logic swiReq // to software interrupt trap
);
   always_comb begin
      haltReq = 1'b0;
      swiReq = 1'b0;
      if (breakReq && !bgActive) begin
         if (haltRoute && bgEnable) begin
            haltReq = 1'b1;
         end else begin
            swiReq = 1'b1;
         end
      end
   end
endmodule

// [dsc_debug_ctrl_checker.sv]
module dsc_debug_ctrl_checker
   import dsc_pkg::*;
(
   input wire logic mclk, // clock
   input wire logic reset_n, // reset
   input wire logic hsel, // select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer
   input wire logic hwrite, // write
   input wire logic [31:0] hwdata, // wdata
   input wire logic hready, // ready in
   input wire logic [31:0] hrdata, // rdata
   input wire logic hreadyout, // ready out
   input wire logic hresp, // response
   input wire logic secured, // secured
   input wire logic traceReqEnable, // trace enable
   input wire logic bgCtrlEnable, // bg enable
   input wire logic bgActive, // bg active
   input wire logic sessionArmed, // armed
   input wire logic [1:0] compBank, // bank
   input wire logic [1:0] reg27Sel, // 0x27 select
   input wire logic traceActive, // tracing
   input wire logic haltOut, // halt
   input wire logic swiOut // swi
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire addrPh = hsel && hready && htrans[1];
   sequence s_ctrlWr;
      addrPh && hwrite && haddr == DSC_CTRL_ADDR ##1 1'b1;
   endsequence
   property p_ok;
      hreadyout && !hresp;
   endproperty
   a_ok: assert property (p_ok) else $error("bus not ready");
   property p_stat;
      addrPh && !hwrite && haddr == DSC_STAT_ADDR |=>
         (hrdata & 32'hffffff78) == 32'h0;
   endproperty
   a_stat: assert property (p_stat) else $error("status pad bits");
   property p_ctrl;
      addrPh && !hwrite && haddr == DSC_CTRL_ADDR |=>
         (hrdata & 32'hffffff64) == 32'h0;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control pad bits");
   property p_bank;
      reg27Sel == compBank;
   endproperty
   a_bank: assert property (p_bank) else $error("bank mismatch");
   property p_notr;
      !traceReqEnable ##1 !traceActive |=> !traceActive;
   endproperty
   a_notr: assert property (p_notr) else $error("trace while off");
   property p_sec;
      secured ##1 !traceActive |=> !traceActive;
   endproperty
   a_sec: assert property (p_sec) else $error("trace while secured");
   property p_nohalt;
      (!bgCtrlEnable) [*2] |-> !haltOut;
   endproperty
   a_nohalt: assert property (p_nohalt) else $error("halt not enabled");
   property p_bgact;
      (bgActive && bgCtrlEnable) [*2] |-> !swiOut;
   endproperty
   a_bgact: assert property (p_bgact) else $error("swi in bg mode");
   property p_arm;
      s_ctrlWr ##0 hwdata[7] |-> ##[1:3] sessionArmed;
   endproperty
   a_arm: assert property (p_arm) else $error("arm not taken");
endmodule

bind dsc_debug_ctrl dsc_debug_ctrl_checker u_chk (.mclk, .reset_n, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .secured, .traceReqEnable, .bgCtrlEnable, .bgActive, .sessionArmed,
   .compBank, .reg27Sel, .traceActive, .haltOut, .swiOut);

// [dsc_trace_store.sv]
module dsc_trace_store #(
   parameter int LINES = 70
) (
   input wire logic mclk, // clock
   input wire logic reset_n, // reset
   input wire logic traceActive, // tracing in progress
   output logic lineStored, // one line stored
   output logic traceDone // session complete
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt_r;
   // stores one line a cycle, then ends the session once
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 0;
         lineStored <= 1'b0;
         traceDone <= 1'b0;
      end else begin
         lineStored <= traceActive && cnt_r < LINES;
         traceDone <= traceActive && cnt_r == LINES;
         cnt_r <= !traceActive ? 0 : (cnt_r <= LINES ? cnt_r + 1 : cnt_r);
      end
   end
endmodule

// [debug_session_control_status_test.sv]
module debug_session_control_status_test;
   import dsc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 0, reset_n = 0, porReset_n = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
   logic [1:0] htrans = 0, compBank, reg27Sel;
   logic secured = 0, trEn = 1, bgEn = 1, bgAct = 0, seqAdv = 0;
   logic [2:0] seqNext = 0;
   logic hreadyout, hresp, armed, trAct, halt, software_interrupt_trap, lineSt, trDone;
   logic [7:0] mCtrl = 0, mStat = 0;
   logic [31:0] st = 32'hf8059de5;
   int n_fail = 0, n_checks = 0, cyc = 0;
   int nHalt = 0, nSwi = 0;
   always #2.5 mclk = ~mclk;
   dsc_debug_ctrl u_dut (.mclk, .reset_n, .porReset_n, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .secured, .traceReqEnable(trEn),
      .triggerAlignBegin(1'b1), .bgCtrlEnable(bgEn), .bgActive(bgAct),
      .seqNext, .seqAdvance(seqAdv), .lineStored(lineSt), .traceDone(trDone),
      .sessionArmed(armed), .compBank, .reg27Sel, .traceActive(trAct),
      .haltOut(halt), .swiOut(software_interrupt_trap));
   dsc_trace_store u_far (.mclk, .reset_n, .traceActive(trAct),
      .lineStored(lineSt), .traceDone(trDone));
   function automatic logic [31:0] xs();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a,
         input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   // model: bits 4:3 frozen while armed, arming restarts status
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      if (a == DSC_CTRL_ADDR) begin
         if (d[7] && !mCtrl[7]) mStat = 8'h01;
         mCtrl = {d[7], 2'h0, (mCtrl[7] ? mCtrl[4:3] : d[4:3]), 1'b0, d[1:0]};
      end
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rv, {24'h0, e});
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (halt === 1'b1) nHalt++;
      if (software_interrupt_trap === 1'b1) nSwi++;
      if (cyc == 5000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      logic [7:0] d;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      porReset_n <= 1'b1;
      @(posedge mclk);
      rd(DSC_CTRL_ADDR, 8'h00);
      rd(DSC_STAT_ADDR, 8'h00);
      rd(32'h88, 8'h00);
      wr(DSC_CTRL_ADDR, 8'h04);
      wr(DSC_CTRL_ADDR, 8'hbf);
      rd(DSC_CTRL_ADDR, mCtrl);
      rd(DSC_STAT_ADDR, mStat);
      chk({30'h0, compBank}, 32'h3);
      chk({30'h0, reg27Sel}, 32'h3);
      wr(DSC_STAT_ADDR, 8'hff);
      rd(DSC_STAT_ADDR, mStat);
      seqNext <= 3'h3;
      seqAdv <= 1'b1;
      @(posedge mclk);
      seqAdv <= 1'b0;
      mStat = 8'h03;
      rd(DSC_STAT_ADDR, mStat);
      repeat (4) begin
         d = 8'(xs()) & 8'h9b | 8'h80;
         wr(DSC_CTRL_ADDR, d);
         rd(DSC_CTRL_ADDR, mCtrl);
         chk({30'h0, compBank}, {30'h0, mCtrl[1:0]});
      end
      wr(DSC_CTRL_ADDR, 8'hc0 | mCtrl[1:0]);
      mStat = 8'h04;
      rd(DSC_STAT_ADDR, mStat);
      chk({31'h0, trAct}, 32'h1);
      wr(DSC_CTRL_ADDR, 8'hc0 | mCtrl[1:0]);
      rd(DSC_STAT_ADDR, mStat);
      repeat (300) if (armed) @(posedge mclk);
      mCtrl[7] = 1'b0;
      mStat = 8'h80;
      rd(DSC_CTRL_ADDR, mCtrl);
      rd(DSC_STAT_ADDR, mStat);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      mCtrl = 8'h00;
      rd(DSC_STAT_ADDR, mStat);
      rd(DSC_CTRL_ADDR, mCtrl);
      secured <= 1'b1;
      trEn <= 1'b0;
      bgEn <= 1'b0;
      wr(DSC_CTRL_ADDR, 8'h88);
      rd(DSC_STAT_ADDR, mStat);
      wr(DSC_CTRL_ADDR, 8'hc8);
      repeat (300) if (armed) @(posedge mclk);
      chk({31'h0, trAct}, 32'h0);
      mStat = 8'h00;
      mCtrl[7] = 1'b0;
      rd(DSC_STAT_ADDR, mStat);
      rd(DSC_CTRL_ADDR, mCtrl);
      chk(nSwi, 32'h1);
      bgAct <= 1'b1;
      bgEn <= 1'b1;
      wr(DSC_CTRL_ADDR, 8'h88);
      wr(DSC_CTRL_ADDR, 8'hc8);
      repeat (300) if (armed) @(posedge mclk);
      mCtrl[7] = 1'b0;
      rd(DSC_CTRL_ADDR, mCtrl);
      chk(nSwi, 32'h1);
      chk(nHalt, 32'h1);
      print_verdict();
   end
endmodule
